// *** i2c_margin_watchdog_cmd.sv ***
`timescale 1ns/1ps
// Operation
// - Each operation needs its own guard byte first
// - Guards are 001 00000 and 011 00000
// - One guard allows two margin bytes
// - Valid watchdog byte after guard starts timer
// - Later kick clears timer only when window open
// - Clearing kick loads new period and window
// - Watchdog guard twice stops and disables timer
// - Any other valid watchdog command re-enables
// - STOP returns interpreter to idle
// - Write-only slave, acknowledges own address
// - Margin supply bit and percent code decode
// - Watchdog codes select period and window
// - Address 11101 plus two strap bits
module i2c_margin_watchdog_cmd
    import margin_watchdog_pkg::*;
#(
    parameter int MS_TICK_CYCLES = TICK_CYCLES
) (
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    input  wire logic       i_link_clk,
    input  wire logic       i_scl,
    input  wire logic       i_sda,
    input  wire logic       i_clock_select_strap,
    input  wire logic       i_address_strap_bit_zero,
    output logic            o_sda_o,
    output logic            o_sda_oe_n,
    output logic [3:0]      o_linear_regulator_output_margin,
    output logic [3:0]      o_switcher_margin,
    output logic            o_supervision_timer_enabled,
    output logic            o_supervision_timer_window_enabled,
    output logic [1:0]      o_supervision_timer_period_sel,
    output logic            o_supervision_timer_window_open,
    output logic            o_supervision_timer_timeout
);
    localparam int PRESCALE_BITS = $clog2(MS_TICK_CYCLES + 1);

    generate
        if (MS_TICK_CYCLES < 1) begin : g_bad_tick
            $error("MS_TICK_CYCLES must be at least one");
        end
    endgenerate

    cmd_byte_link_if link ();

    i2c_command_byte_receiver u_receiver (
        .i_link_clk               (i_link_clk),
        .i_rst                    (i_rst),
        .i_scl                    (i_scl),
        .i_sda                    (i_sda),
        .i_clock_select_strap     (i_clock_select_strap),
        .i_address_strap_bit_zero (i_address_strap_bit_zero),
        .o_sda_o                  (o_sda_o),
        .o_sda_oe_n               (o_sda_oe_n),
        .link                     (link.producer)
    );

    logic [2:0]               byte_tgl_sync_reg;
    logic [2:0]               frame_tgl_sync_reg;
    logic                     byte_event;
    logic                     frame_event;
    logic [7:0]               cmd_byte_reg;
    logic                     cmd_valid_reg;
    logic                     frame_pending_reg;
    seq_state_e               seq_reg;
    logic                     margin_count_reg;
    logic [2:0]               op_field;
    logic [4:0]               value_field;
    logic                     is_margin_guard;
    logic                     is_wd_guard;
    logic                     is_margin_code;
    logic                     is_wd_code;
    logic                     margin_apply;
    logic                     wd_disable;
    logic                     wd_command;
    logic                     kick_accept;
    logic                     tick;
    logic                     expire;
    logic [PRESCALE_BITS-1:0] prescale_reg;
    logic [WD_MS_BITS-1:0]    elapsed_reg;
    logic [WD_MS_BITS-1:0]    period_ms;

    // Toggles only; the byte bus is stable for many link cycles after a toggle
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            byte_tgl_sync_reg  <= 3'h0;
            frame_tgl_sync_reg <= 3'h0;
        end else begin
            byte_tgl_sync_reg  <= {byte_tgl_sync_reg[1:0], link.byte_toggle};
            frame_tgl_sync_reg <= {frame_tgl_sync_reg[1:0], link.frame_toggle};
        end
    end

    assign byte_event  = byte_tgl_sync_reg[2] ^ byte_tgl_sync_reg[1];
    assign frame_event = frame_tgl_sync_reg[2] ^ frame_tgl_sync_reg[1];

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cmd_byte_reg      <= 8'h00;
            cmd_valid_reg     <= 1'b0;
            frame_pending_reg <= 1'b0;
        end else begin
            cmd_valid_reg     <= byte_event;
            frame_pending_reg <= frame_event;
            if (byte_event) begin
                cmd_byte_reg <= link.byte_data;
            end
        end
    end

    assign op_field        = cmd_byte_reg[OP_FIELD_MSB:OP_FIELD_LSB];
    assign value_field     = cmd_byte_reg[VALUE_FIELD_MSB:0];
    assign is_margin_guard = (op_field == OP_MARGIN) && (value_field == VALUE_NULL);
    assign is_wd_guard     = (op_field == OP_WATCHDOG) && (value_field == VALUE_NULL);
    assign is_margin_code  = (op_field == OP_MARGIN) && (value_field[3:0] != MARGIN_UNDEFINED);
    assign is_wd_code      = (op_field == OP_WATCHDOG)
                             && (value_field[VALUE_FIELD_MSB:VALUE_FIELD_MSB-1] == WD_CODE_PREFIX);

    // Only bytes behind a matching guard take effect
    assign margin_apply = cmd_valid_reg && (seq_reg == SEQ_MARGIN) && is_margin_code;
    assign wd_disable   = cmd_valid_reg && (seq_reg == SEQ_WATCHDOG) && is_wd_guard;
    assign wd_command   = cmd_valid_reg && (seq_reg == SEQ_WATCHDOG) && is_wd_code;

    // Inside the margin sequence 001 00000 is linear nominal, not a new guard
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            seq_reg          <= SEQ_IDLE;
            margin_count_reg <= 1'b0;
        end else if (frame_pending_reg) begin
            seq_reg          <= SEQ_IDLE;
            margin_count_reg <= 1'b0;
        end else if (cmd_valid_reg) begin
            case (seq_reg)
                SEQ_MARGIN: begin
                    if (margin_apply && !margin_count_reg) begin
                        margin_count_reg <= 1'b1;
                    end else if (is_wd_guard && !margin_apply) begin
                        seq_reg <= SEQ_WATCHDOG;
                    end else begin
                        seq_reg <= SEQ_IDLE;
                    end
                end
                SEQ_WATCHDOG: begin
                    if (is_margin_guard) begin
                        seq_reg          <= SEQ_MARGIN;
                        margin_count_reg <= 1'b0;
                    end else begin
                        seq_reg <= SEQ_IDLE;
                    end
                end
                default: begin
                    margin_count_reg <= 1'b0;
                    if (is_margin_guard) begin
                        seq_reg <= SEQ_MARGIN;
                    end else if (is_wd_guard) begin
                        seq_reg <= SEQ_WATCHDOG;
                    end else begin
                        seq_reg <= SEQ_IDLE;
                    end
                end
            endcase
        end
    end

    // Each byte steers only the supply its top value bit selects
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_linear_regulator_output_margin <= MARGIN_NOMINAL;
            o_switcher_margin                <= MARGIN_NOMINAL;
        end else if (margin_apply) begin
            if (value_field[MARGIN_SUPPLY_BIT]) begin
                o_switcher_margin <= value_field[3:0];
            end else begin
                o_linear_regulator_output_margin <= value_field[3:0];
            end
        end
    end

    always_comb begin
        case (o_supervision_timer_period_sel)
            2'h0:    period_ms = WD_MS_BITS'(WD_PERIOD0_MS);
            2'h1:    period_ms = WD_MS_BITS'(WD_PERIOD1_MS);
            2'h2:    period_ms = WD_MS_BITS'(WD_PERIOD2_MS);
            default: period_ms = WD_MS_BITS'(WD_PERIOD3_MS);
        endcase
    end

    // Early kick in a closed window is dropped, not punished
    assign kick_accept = wd_command
                         && (!o_supervision_timer_enabled
                             || !o_supervision_timer_window_enabled
                             || o_supervision_timer_window_open);

    assign tick   = o_supervision_timer_enabled
                    && (prescale_reg == PRESCALE_BITS'(MS_TICK_CYCLES - 1));
    assign expire = tick && (elapsed_reg == period_ms - WD_MS_BITS'(1));

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_supervision_timer_window_enabled <= 1'b0;
            o_supervision_timer_period_sel     <= WD_PERIOD_RESET;
        end else if (kick_accept) begin
            o_supervision_timer_window_enabled <= value_field[WD_WINDOW_BIT];
            o_supervision_timer_period_sel     <= value_field[1:0];
        end
    end

    // Expiry wins over a kick landing in the same cycle
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_supervision_timer_enabled <= 1'b0;
            o_supervision_timer_timeout <= 1'b0;
        end else if (expire) begin
            o_supervision_timer_enabled <= 1'b0;
            o_supervision_timer_timeout <= 1'b1;
        end else if (wd_disable) begin
            o_supervision_timer_enabled <= 1'b0;
            o_supervision_timer_timeout <= 1'b0;
        end else if (kick_accept) begin
            o_supervision_timer_enabled <= 1'b1;
            o_supervision_timer_timeout <= 1'b0;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            prescale_reg <= '0;
            elapsed_reg  <= '0;
        end else if (kick_accept || wd_disable || expire || !o_supervision_timer_enabled) begin
            prescale_reg <= '0;
            elapsed_reg  <= '0;
        end else if (tick) begin
            prescale_reg <= '0;
            elapsed_reg  <= elapsed_reg + WD_MS_BITS'(1);
        end else begin
            prescale_reg <= prescale_reg + PRESCALE_BITS'(1);
        end
    end

    // Window opens for the second half of the period
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_supervision_timer_window_open <= 1'b0;
        end else begin
            o_supervision_timer_window_open <= o_supervision_timer_enabled
                && !kick_accept
                && (!o_supervision_timer_window_enabled
                    || (elapsed_reg >= (period_ms >> 1)));
        end
    end

endmodule : i2c_margin_watchdog_cmd

// *** margin_watchdog_pkg.sv ***
package margin_watchdog_pkg;

    localparam logic [4:0] SLAVE_ADDR_FIXED   = 5'h1D;
    localparam int         ADDR_BYTE_BITS     = 8;

    localparam logic [2:0] OP_MARGIN          = 3'h1;
    localparam logic [2:0] OP_WATCHDOG        = 3'h3;
    localparam logic [4:0] VALUE_NULL         = 5'h00;
    localparam int         OP_FIELD_MSB       = 7;
    localparam int         OP_FIELD_LSB       = 5;
    localparam int         VALUE_FIELD_MSB    = 4;

    localparam int         MARGIN_SUPPLY_BIT  = 4;
    localparam logic [3:0] MARGIN_NOMINAL     = 4'h0;
    localparam logic [3:0] MARGIN_UNDEFINED   = 4'hF;
    localparam int         MARGIN_BYTES_MAX   = 2;

    localparam logic [1:0] WD_CODE_PREFIX     = 2'h1;
    localparam int         WD_WINDOW_BIT      = 2;
    localparam logic [1:0] WD_PERIOD_RESET    = 2'h0;

    localparam int         WD_PERIOD0_MS      = 1280;
    localparam int         WD_PERIOD1_MS      = 320;
    localparam int         WD_PERIOD2_MS      = 80;
    localparam int         WD_PERIOD3_MS      = 20;
    localparam int         WD_MS_BITS         = 11;

    localparam int         CLK_FREQ_HZ        = 25_000_000;
    localparam int         TICK_PERIOD_US     = 1000;
    localparam int         TICK_CYCLES        = (CLK_FREQ_HZ / 1_000_000) * TICK_PERIOD_US;

    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_MARGIN,
        SEQ_WATCHDOG
    } seq_state_e;

    typedef enum logic [2:0] {
        RX_IDLE,
        RX_ADDR,
        RX_ACK_ADDR,
        RX_DATA,
        RX_ACK_DATA
    } rx_state_e;

endpackage : margin_watchdog_pkg

// *** cmd_byte_link_if.sv ***
`timescale 1ns/1ps
interface cmd_byte_link_if;
    logic [7:0] byte_data;
    logic       byte_toggle;
    logic       frame_toggle;

    modport producer (
        output byte_data,
        output byte_toggle,
        output frame_toggle
    );

    modport consumer (
        input  byte_data,
        input  byte_toggle,
        input  frame_toggle
    );
endinterface : cmd_byte_link_if

// *** i2c_command_byte_receiver.sv ***
`timescale 1ns/1ps
module i2c_command_byte_receiver
    import margin_watchdog_pkg::*;
(
    input  wire logic        i_link_clk,
    input  wire logic        i_rst,
    input  wire logic        i_scl,
    input  wire logic        i_sda,
    input  wire logic        i_clock_select_strap,
    input  wire logic        i_address_strap_bit_zero,
    output logic             o_sda_o,
    output logic             o_sda_oe_n,
    cmd_byte_link_if.producer link
);
    logic [1:0] rst_sync_reg;
    logic       link_rst;
    logic [1:0] scl_sync_reg;
    logic [1:0] sda_sync_reg;
    logic [1:0] a1_sync_reg;
    logic [1:0] a0_sync_reg;
    logic       scl_prev_reg;
    logic       sda_prev_reg;
    rx_state_e  state_reg;
    logic [7:0] shift_reg;
    logic [3:0] bit_cnt_reg;
    logic       scl_rise;
    logic       scl_fall;
    logic       start_seen;
    logic       stop_seen;
    logic       addr_match;

    // Reset asserts at once, releases on the link clock
    always_ff @(posedge i_link_clk or posedge i_rst) begin
        if (i_rst) begin
            rst_sync_reg <= 2'h3;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b0};
        end
    end
    assign link_rst = rst_sync_reg[1];

    always_ff @(posedge i_link_clk or posedge link_rst) begin
        if (link_rst) begin
            scl_sync_reg <= 2'h3;
            sda_sync_reg <= 2'h3;
            a1_sync_reg  <= 2'h3;
            a0_sync_reg  <= 2'h3;
            scl_prev_reg <= 1'b1;
            sda_prev_reg <= 1'b1;
        end else begin
            scl_sync_reg <= {scl_sync_reg[0], i_scl};
            sda_sync_reg <= {sda_sync_reg[0], i_sda};
            a1_sync_reg  <= {a1_sync_reg[0], i_clock_select_strap};
            a0_sync_reg  <= {a0_sync_reg[0], i_address_strap_bit_zero};
            scl_prev_reg <= scl_sync_reg[1];
            sda_prev_reg <= sda_sync_reg[1];
        end
    end

    assign scl_rise   = scl_sync_reg[1] & ~scl_prev_reg;
    assign scl_fall   = ~scl_sync_reg[1] & scl_prev_reg;
    assign start_seen = scl_sync_reg[1] & scl_prev_reg & sda_prev_reg & ~sda_sync_reg[1];
    assign stop_seen  = scl_sync_reg[1] & scl_prev_reg & ~sda_prev_reg & sda_sync_reg[1];
    // Write direction only; a read request is left unanswered
    assign addr_match = (shift_reg == {SLAVE_ADDR_FIXED, a1_sync_reg[1], a0_sync_reg[1], 1'b0});

    always_ff @(posedge i_link_clk or posedge link_rst) begin
        if (link_rst) begin
            state_reg         <= RX_IDLE;
            shift_reg         <= 8'h00;
            bit_cnt_reg       <= 4'h0;
            o_sda_o           <= 1'b0;
            o_sda_oe_n        <= 1'b1;
            link.byte_data    <= 8'h00;
            link.byte_toggle  <= 1'b0;
            link.frame_toggle <= 1'b0;
        end else if (start_seen) begin
            state_reg         <= RX_ADDR;
            bit_cnt_reg       <= 4'h0;
            o_sda_oe_n        <= 1'b1;
            link.frame_toggle <= ~link.frame_toggle;
        end else if (stop_seen) begin
            state_reg         <= RX_IDLE;
            o_sda_oe_n        <= 1'b1;
            link.frame_toggle <= ~link.frame_toggle;
        end else begin
            case (state_reg)
                RX_ADDR, RX_DATA: begin
                    if (scl_rise) begin
                        shift_reg   <= {shift_reg[6:0], sda_sync_reg[1]};
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    end else if (scl_fall && bit_cnt_reg == 4'(ADDR_BYTE_BITS)) begin
                        if (state_reg == RX_DATA) begin
                            link.byte_data   <= shift_reg;
                            link.byte_toggle <= ~link.byte_toggle;
                            o_sda_oe_n       <= 1'b0;
                            state_reg        <= RX_ACK_DATA;
                        end else if (addr_match) begin
                            o_sda_oe_n <= 1'b0;
                            state_reg  <= RX_ACK_ADDR;
                        end else begin
                            state_reg <= RX_IDLE;
                        end
                    end
                end
                RX_ACK_ADDR, RX_ACK_DATA: begin
                    if (scl_fall) begin
                        o_sda_oe_n  <= 1'b1;
                        bit_cnt_reg <= 4'h0;
                        state_reg   <= RX_DATA;
                    end
                end
                default: begin
                    state_reg <= RX_IDLE;
                end
            endcase
        end
    end
endmodule : i2c_command_byte_receiver

// *** i2c_margin_watchdog_cmd_properties.sv ***
`timescale 1ns/1ps
module i2c_margin_watchdog_cmd_properties
    import margin_watchdog_pkg::*;
#(
    parameter int MS_TICK_CYCLES = TICK_CYCLES
) (
    input wire logic       i_clk,
    input wire logic       i_rst,
    input wire logic       i_link_clk,
    input wire logic       i_scl,
    input wire logic       o_sda_o,
    input wire logic       o_sda_oe_n,
    input wire logic [3:0] o_linear_regulator_output_margin,
    input wire logic [3:0] o_switcher_margin,
    input wire logic       o_supervision_timer_enabled,
    input wire logic       o_supervision_timer_window_enabled,
    input wire logic [1:0] o_supervision_timer_period_sel,
    input wire logic       o_supervision_timer_window_open,
    input wire logic       o_supervision_timer_timeout
);
    // Small slack: the start may show a cycle or two after the kick edge
    localparam int MIN_EXPIRY = WD_PERIOD3_MS * MS_TICK_CYCLES - 4;
    logic [31:0] run_cnt_reg;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            run_cnt_reg <= 32'h0;
        end else if (!o_supervision_timer_enabled) begin
            run_cnt_reg <= 32'h0;
        end else if (run_cnt_reg != 32'hFFFF_FFFF) begin
            run_cnt_reg <= run_cnt_reg + 32'h1;
        end
    end

    sequence ack_begin;
        $fell(o_sda_oe_n);
    endsequence
    sequence ack_held;
        !o_sda_oe_n [*4];
    endsequence

    AST_LINEAR_CODE_DEFINED: assert property (@(posedge i_clk) disable iff (i_rst)
        o_linear_regulator_output_margin != MARGIN_UNDEFINED)
        else $error("linear margin undefined");
    AST_SWITCH_CODE_DEFINED: assert property (@(posedge i_clk) disable iff (i_rst)
        o_switcher_margin != MARGIN_UNDEFINED)
        else $error("switcher margin undefined");
    AST_WINDOW_NEEDS_TIMER: assert property (@(posedge i_clk) disable iff (i_rst)
        o_supervision_timer_window_open |->
        o_supervision_timer_enabled || $past(o_supervision_timer_enabled))
        else $error("window open, timer stopped");
    AST_CONFIG_ONLY_WITH_START: assert property (@(posedge i_clk) disable iff (i_rst)
        !$stable({o_supervision_timer_window_enabled, o_supervision_timer_period_sel}) |->
        o_supervision_timer_enabled)
        else $error("setting changed without start");
    AST_EXPIRY_STOPS_TIMER: assert property (@(posedge i_clk) disable iff (i_rst)
        $rose(o_supervision_timer_timeout) |-> !o_supervision_timer_enabled)
        else $error("timer runs after timeout");
    AST_NO_EARLY_EXPIRY: assert property (@(posedge i_clk) disable iff (i_rst)
        $rose(o_supervision_timer_timeout) |-> run_cnt_reg >= MIN_EXPIRY)
        else $error("timeout too early");
    AST_START_CLEARS_TIMEOUT: assert property (@(posedge i_clk) disable iff (i_rst)
        $rose(o_supervision_timer_enabled) |-> ##[0:1] !o_supervision_timer_timeout)
        else $error("timeout kept after start");
    AST_ACK_DRIVES_LOW: assert property (@(posedge i_link_clk) disable iff (i_rst)
        !o_sda_oe_n |-> !o_sda_o)
        else $error("data line driven high");
    AST_ACK_CHANGES_SCL_LOW: assert property (@(posedge i_link_clk) disable iff (i_rst)
        $changed(o_sda_oe_n) |-> !i_scl && !$past(i_scl))
        else $error("data drive changed while clock high");
    AST_ACK_HOLDS: assert property (@(posedge i_link_clk) disable iff (i_rst)
        ack_begin |-> ack_held)
        else $error("acknowledge too short");
endmodule : i2c_margin_watchdog_cmd_properties

bind i2c_margin_watchdog_cmd i2c_margin_watchdog_cmd_properties #(
    .MS_TICK_CYCLES(MS_TICK_CYCLES)
) i2c_margin_watchdog_cmd_properties_i (
    .i_clk, .i_rst, .i_link_clk, .i_scl, .o_sda_o, .o_sda_oe_n, .o_linear_regulator_output_margin,
    .o_switcher_margin, .o_supervision_timer_enabled, .o_supervision_timer_window_enabled,
    .o_supervision_timer_period_sel, .o_supervision_timer_window_open,
    .o_supervision_timer_timeout
);

// *** i2c_host_model.sv ***
`timescale 1ns/1ps
module i2c_host_model #(
    parameter int HALF = 7
) (
    input  wire logic i_link_clk,
    input  wire logic i_sda,
    output logic      o_scl,
    output logic      o_sda_low
);
    // Lines released between frames
    initial begin
        o_scl = 1'b1;
        o_sda_low = 1'b0;
    end

    task automatic half_bit();
        repeat (HALF) @(posedge i_link_clk);
    endtask : half_bit

    // Also serves as a repeated start
    task automatic start_cond();
        @(posedge i_link_clk);
        o_sda_low <= 1'b0;
        half_bit();
        o_scl <= 1'b1;
        half_bit();
        o_sda_low <= 1'b1;
        half_bit();
        o_scl <= 1'b0;
        repeat (2) @(posedge i_link_clk);
    endtask : start_cond

    // Data changes only inside the low phase
    task automatic write_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            o_sda_low <= ~b[i];
            half_bit();
            o_scl <= 1'b1;
            half_bit();
            o_scl <= 1'b0;
            repeat (2) @(posedge i_link_clk);
        end
        o_sda_low <= 1'b0;
        half_bit();
        o_scl <= 1'b1;
        half_bit();
        ack = ~i_sda;
        o_scl <= 1'b0;
        repeat (2) @(posedge i_link_clk);
    endtask : write_byte

    task automatic stop_cond();
        @(posedge i_link_clk);
        o_sda_low <= 1'b1;
        half_bit();
        o_scl <= 1'b1;
        half_bit();
        o_sda_low <= 1'b0;
        half_bit();
    endtask : stop_cond
endmodule : i2c_host_model

// *** i2c_margin_watchdog_cmd_tb.sv ***
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin errors++; \
$display("CHECK FAILED %s expected %0h seen %0h", n, e, g); end end
module i2c_margin_watchdog_cmd_tb
    import margin_watchdog_pkg::*;
;
    localparam int MS = 100;
    logic        i_clk, i_rst, lclk, strap1, strap0, scl, sda_low, sda_o, sda_oe_n, sda;
    logic [3:0]  lin, sw, e_lin, e_sw;
    logic        en, win, wopen, tmo, e_en, e_win, win_ok;
    logic [1:0]  per, e_per;
    logic [7:0]  q[$];
    logic [31:0] r;
    int          errors, checks_done, st, cnt;

    // Open-drain line with pull-up
    assign sda = (sda_low || (sda_oe_n === 1'b0 && sda_o === 1'b0)) ? 1'b0 : 1'b1;

    initial begin
        i_clk = 1'b0;
        forever #20 i_clk = ~i_clk;
    end
    initial begin
        lclk = 1'b0;
        #7;
        forever #15 lclk = ~lclk;
    end

    i2c_margin_watchdog_cmd #(.MS_TICK_CYCLES(MS)) i2c_margin_watchdog_cmd_i (
        .i_clk(i_clk), .i_rst(i_rst), .i_link_clk(lclk), .i_scl(scl), .i_sda(sda),
        .i_clock_select_strap(strap1), .i_address_strap_bit_zero(strap0),
        .o_sda_o(sda_o), .o_sda_oe_n(sda_oe_n), .o_linear_regulator_output_margin(lin),
        .o_switcher_margin(sw), .o_supervision_timer_enabled(en),
        .o_supervision_timer_window_enabled(win), .o_supervision_timer_period_sel(per),
        .o_supervision_timer_window_open(wopen), .o_supervision_timer_timeout(tmo));
    i2c_host_model i2c_host_model_i (.i_link_clk(lclk), .i_sda(sda), .o_scl(scl),
        .o_sda_low(sda_low));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    function automatic logic [7:0] dev();
        return {SLAVE_ADDR_FIXED, strap1, strap0, 1'b0};
    endfunction : dev

    // Reference interpreter; win_ok: window open
    task automatic model(input logic [7:0] b);
        if (st == 1 && b[7:5] == OP_MARGIN && b[3:0] != MARGIN_UNDEFINED) begin
            if (b[4]) e_sw = b[3:0]; else e_lin = b[3:0];
            cnt++;
            st = (cnt == 2) ? 0 : 1;
        end else if (st == 2 && b == 8'h60) begin
            e_en = 1'b0;
            st = 0;
        end else if (st == 2 && b[7:3] == 5'b01101 && (!e_en || !e_win || win_ok)) begin
            {e_en, e_win, e_per} = {1'b1, b[2:0]};
            st = 0;
        end else begin
            st = (b == 8'h20) ? 1 : (b == 8'h60) ? 2 : 0;
            cnt = 0;
        end
    endtask : model

    task automatic chk_all();
        @(negedge i_clk);
        `CHK("linear margin", e_lin, lin)
        `CHK("switcher margin", e_sw, sw)
        `CHK("timer enabled", e_en, en)
        `CHK("window mode", e_win, win)
        `CHK("period select", e_per, per)
    endtask : chk_all

    task automatic xfer(input logic [7:0] a, input logic [7:0] d[$], input logic ok);
        logic ack;
        st = 0;
        cnt = 0;
        i2c_host_model_i.start_cond();
        i2c_host_model_i.write_byte(a, ack);
        `CHK("address ack", ok, ack)
        foreach (d[k]) begin
            i2c_host_model_i.write_byte(d[k], ack);
            `CHK("data ack", ok, ack)
            if (ok) model(d[k]);
        end
        i2c_host_model_i.stop_cond();
        repeat (20) @(posedge i_clk);
        chk_all();
    endtask : xfer

    task automatic wait_high(ref logic s, input int bound);
        for (int i = 0; i < bound && s !== 1'b1; i++) @(negedge i_clk);
        `CHK("bounded wait", 1'b1, s)
    endtask : wait_high

    task automatic do_reset();
        @(posedge i_clk);
        i_rst <= 1'b1;
        repeat (4) @(posedge i_clk);
        i_rst <= 1'b0;
        {e_lin, e_sw, e_en, e_win, e_per} = '0;
        chk_all();
        `CHK("window open", 1'b0, wopen)
        `CHK("timeout", 1'b0, tmo)
        `CHK("sda drive", 1'b1, sda_oe_n)
        repeat (10) @(posedge i_clk);
    endtask : do_reset

    task automatic finish_test();
        $display("Checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : finish_test

    initial begin
        #4_000_000;
        errors++;
        $display("CHECK FAILED run limit expected done seen running");
        finish_test();
    end

    initial begin
        {i_rst, strap1, strap0, win_ok} = 4'hE;
        {errors, checks_done, st, cnt} = '0;
        r = 32'h9c2e5119;
        do_reset();
        for (int i = 0; i < 4; i++) begin
            @(posedge i_clk);
            {strap1, strap0} <= i[1:0];
            repeat (10) @(posedge i_clk);
            r = lfsr(r);
            xfer(dev() ^ {r[6:0] | 7'h01, 1'b0}, '{8'h20, 8'h25}, 1'b0);
            xfer(dev() | 8'h01, '{8'h20, 8'h3C}, 1'b0);
            xfer(dev(), '{8'h20, {6'h09, i[1:0]}}, 1'b1);
        end
        for (int n = 0; n < 16; n++) begin
            q = {};
            repeat (4) begin
                r = lfsr(r);
                case (r[9:8])
                    2'd0: q.push_back(8'h20);
                    2'd3: q.push_back({1'b1, r[6:0]});
                    default: q.push_back({3'b001, r[4:0]});
                endcase
            end
            xfer(dev(), q, 1'b1);
        end
        xfer(dev(), '{8'h20}, 1'b1);
        xfer(dev(), '{8'h2B}, 1'b1);
        for (int k = 0; k < 8; k++) begin
            xfer(dev(), '{8'h60, 8'h60}, 1'b1);
            xfer(dev(), '{8'h60, 8'h68 | k[7:0]}, 1'b1);
        end
        `CHK("window shut", 1'b0, wopen)
        xfer(dev(), '{8'h60, 8'h6E}, 1'b1);
        wait_high(wopen, 2000);
        win_ok = 1'b1;
        xfer(dev(), '{8'h60, 8'h6E}, 1'b1);
        wait_high(wopen, 5000);
        xfer(dev(), '{8'h60, 8'h6B}, 1'b1);
        repeat (1500) @(posedge i_clk);
        `CHK("no early timeout", 1'b0, tmo)
        wait_high(tmo, 1000);
        e_en = 1'b0;
        chk_all();
        xfer(dev(), '{8'h60, 8'h69}, 1'b1);
        `CHK("timeout cleared", 1'b0, tmo)
        xfer(dev(), '{8'h60, 8'h60}, 1'b1);
        do_reset();
        finish_test();
    end
endmodule : i2c_margin_watchdog_cmd_tb
